/* File: shared/dmab_pkg.sv */
package dmab_pkg;
  // Structure
  localparam int NH    = 2;
  localparam int NM    = 4;
  localparam int OPW   = 18;
  localparam int WIDEW = 36;
  localparam int W9    = 9;
  localparam int W12   = 12;
  localparam int SHW   = 32;
  localparam int SHH   = 16;
  localparam int ACC_W = 44;
  localparam int RES_W = 88;
  localparam int LOOP_LSB = 26;
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  // Half configuration fields
  localparam int CFG_W      = 16;
  localparam int MODE_LSB   = 0;
  localparam int MODE_W     = 3;
  localparam int WID_LSB    = 3;
  localparam int WID_W      = 2;
  localparam int CFG_SUB    = 5;
  localparam int CFG_PIPE   = 6;
  localparam int CFG_OUT    = 7;
  localparam int CFG_CHAIN  = 8;
  localparam int CFG_RND    = 9;
  localparam int CFG_SAT    = 10;
  localparam int CFG_TAP    = 11;
  localparam int CFG_LOOP   = 12;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Status fields
  localparam int STAT_AOVF  = 0;
  localparam int STAT_SOVF  = 2;
  localparam int STAT_CSOVF = 4;
  // Rounding and saturation defaults
  localparam int RND_BIT_DEF = 18;
  localparam int SAT_W_DEF   = 36;

  typedef enum logic [2:0] {
    DMAB_IND, DMAB_TWO, DMAB_FOUR, DMAB_ACC, DMAB_SHIFT, DMAB_HP
  } dmab_mode_t;
  typedef enum logic [1:0] {DMAB_W9, DMAB_W12, DMAB_W18, DMAB_W36} dmab_width_t;
  typedef enum logic [2:0] {
    DMAB_SH_LSL, DMAB_SH_LSR, DMAB_SH_ASL, DMAB_SH_ASR, DMAB_SH_ROT
  } dmab_shop_t;

  typedef struct packed {
    logic [NH-1:0][CFG_W-1:0]        cfg;
    logic [NH-1:0][NM-1:0][OPW-1:0]  a;
    logic [NH-1:0][NM-1:0][OPW-1:0]  b;
    logic [NH-1:0]                   sa;
    logic [NH-1:0]                   sb;
    logic [NH-1:0]                   asub;
    logic [NH-1:0][MODE_W-1:0]       sop;
    logic [NH-1:0][RES_W-1:0]        pipe;
    logic [NH-1:0][RES_W-1:0]        outr;
    logic [NH-1:0]                   aovf;
    logic [NH-1:0]                   sovf;
    logic [NH-1:0]                   csovf;
    logic [31:0]                     rdata;
  } dmab_state_t;
endpackage

/* File: src/dmab_core.sv */
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Contract
// - Each unit multiplies two 18-bit pairs and adds or subtracts them to 37 bits.
// - Signed operands and results are two's complement only.
// - Two two-multiplier adders per half, eight multipliers per block.
// - Four-multiplier mode sums both 37-bit unit results into 38 bits.
// - Accumulate adds or subtracts the sum to the registered 44-bit output.
// - Bypass allowed except accumulate and loopback, which keep a register stage.
// - Chain adder adds the preceding 44-bit result and passes it on or out.
// - One input register bank can act as a tap delay line.
// - Shift kind can change every cycle among shifts and rotation.
// - Shift works on 32 bits in 36-bit width, one shifter per half.
// - Six modes: independent, two-add, four-add, accumulate, shift, 18x36 add.
// - Independent widths 9, 12, 18, 36; round and saturate only at 18.
// - Loopback on one multiplier per half, others stay ordinary.
// - Two identical halves, each with four 18x18 multipliers.
// - Halves run modes independently, sharing clock, enable and clear.
// - Status outputs flag accumulator and saturation overflow.
// - Separate status output flags chain sum saturation overflow.
// - Without chaining, the second-adder register is the output register.
// - Registers capture on rising edge and hold zero after power-up.
// - Sign controls mark A or B signed; product signed if either is.
// - Second-stage adders are 44 bits, one per half.
module dmab_core #(
  parameter int RND_BIT = dmab_pkg::RND_BIT_DEF,
  parameter int SAT_W   = dmab_pkg::SAT_W_DEF
) (
  // Clock and asynchronous clear
  input  wire logic                                     pclk,
  input  wire logic                                     presetn,
  // APB slave
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [7:0]                               paddr,
  input  wire logic [31:0]                              pwdata,
  output logic      [31:0]                              prdata,
  output logic                                          pready,
  output logic                                          pslverr,
  // Operands and dynamic controls
  input  wire logic                                     ena,
  input  wire logic [1:0][3:0][17:0]                    op_a,
  input  wire logic [1:0][3:0][17:0]                    op_b,
  input  wire logic [1:0]                               sign_a,
  input  wire logic [1:0]                               sign_b,
  input  wire logic [1:0]                               acc_sub,
  input  wire logic [1:0][2:0]                          shift_op,
  // Neighbour links
  input  wire logic [17:0]                              scan_in,
  output logic      [17:0]                              scan_out,
  input  wire logic [43:0]                              chain_in,
  output logic      [43:0]                              chain_out,
  // Results and status
  output logic      [1:0][87:0]                         result,
  output logic      [1:0]                               acc_ovf,
  output logic      [1:0]                               sat_ovf,
  output logic      [1:0]                               chain_sat_ovf
);

  localparam int NH  = dmab_pkg::NH;
  localparam int NM  = dmab_pkg::NM;
  localparam int AW  = dmab_pkg::ACC_W;
  localparam int OPW = dmab_pkg::OPW;
  localparam logic [43:0] SAT_MAX  = 44'((45'(1) << (SAT_W - 1)) - 45'(1));
  localparam logic [43:0] SAT_MIN  = ~SAT_MAX;
  localparam logic [43:0] WRAP_MAX = {1'b0, {(AW - 1){1'b1}}};
  localparam logic [43:0] RND_HALF = 44'(44'(1) << (RND_BIT - 1));
  localparam logic [43:0] RND_MASK = 44'((45'(1) << RND_BIT) - 45'(1));

  if (RND_BIT < 1 || RND_BIT > AW - 2) begin : g_bad_rnd
    $error("RND_BIT out of range");
  end
  if (SAT_W < 2 || SAT_W > AW) begin : g_bad_sat
    $error("SAT_W out of range");
  end

  dmab_pkg::dmab_state_t state_ff;
  dmab_pkg::dmab_state_t nxt_state;
  logic [1:0][43:0]      z_dbg;

  // Sign-extend the low w bits of v when s is set, else zero-extend
  function automatic logic [36:0] sx(input logic [35:0] v, input int w, input logic s);
    logic [36:0] r;
    r = '0;
    for (int i = 0; i < 37; i++) begin
      r[i] = (i < w) ? v[i] : (s & v[w-1]);
    end
    return r;
  endfunction

  function automatic logic signed [73:0] mul(input logic [35:0] x, input logic [35:0] y,
                                            input int wx, input int wy,
                                            input logic sgx, input logic sgy);
    return $signed(sx(x, wx, sgx)) * $signed(sx(y, wy, sgy));
  endfunction

  function automatic logic [31:0] shf(input logic [31:0] v, input logic [4:0] n,
                                      input logic [2:0] op);
    logic [63:0] r64;
    r64 = {v, v} << n;
    case (dmab_pkg::dmab_shop_t'(op))
      dmab_pkg::DMAB_SH_LSL, dmab_pkg::DMAB_SH_ASL: return v << n;
      dmab_pkg::DMAB_SH_LSR: return v >> n;
      dmab_pkg::DMAB_SH_ASR: return 32'($signed(v) >>> n);
      dmab_pkg::DMAB_SH_ROT: return r64[63:32];
      default: return v;
    endcase
  endfunction

  function automatic logic [43:0] rnd(input logic [43:0] v, input logic en);
    return en ? ((v + RND_HALF) & ~RND_MASK) : v;
  endfunction

  // Returns {overflow, value}
  function automatic logic [44:0] sat(input logic [43:0] v, input logic en);
    logic ones;
    logic zeros;
    ones  = &v[43:SAT_W-1];
    zeros = ~|v[43:SAT_W-1];
    if (!en || ones || zeros) return {1'b0, v};
    return {1'b1, v[43] ? SAT_MIN : SAT_MAX};
  endfunction

  always_comb begin
    dmab_pkg::dmab_mode_t        md;
    dmab_pkg::dmab_width_t       wd;
    logic [15:0]                 cf;
    logic [3:0][73:0]            m;
    logic [36:0]                 p0;
    logic [36:0]                 p1;
    logic [87:0]                 s1;
    logic [87:0]                 stg;
    logic [87:0]                 s2;
    logic [43:0]                 z;
    logic [43:0]                 cin;
    logic [44:0]                 c;
    logic [44:0]                 t0;
    logic [44:0]                 t1;
    logic signed [73:0]          hp0;
    logic signed [73:0]          hp1;
    logic [1:0][87:0]            res;
    logic                        fa;
    logic                        fs;
    logic                        fc;
    logic                        fb;
    logic                        hit;
    md  = dmab_pkg::DMAB_IND;
    wd  = dmab_pkg::DMAB_W18;
    cf  = '0;
    m   = '0;
    p0  = '0;
    p1  = '0;
    s1  = '0;
    stg = '0;
    s2  = '0;
    z   = '0;
    cin = '0;
    c   = '0;
    t0  = '0;
    t1  = '0;
    hp0 = '0;
    hp1 = '0;
    res = '0;
    fa  = 1'b0;
    fs  = 1'b0;
    fc  = 1'b0;
    fb  = 1'b0;
    z_dbg = '0;
    nxt_state = state_ff;
    // Halves share clock, enable and clear, and half1 takes the tap and chain links from half0; each has its own config
    for (int h = 0; h < NH; h++) begin
      cf = state_ff.cfg[h];
      md = dmab_pkg::dmab_mode_t'(cf[dmab_pkg::MODE_LSB +: dmab_pkg::MODE_W]);
      wd = dmab_pkg::dmab_width_t'(cf[dmab_pkg::WID_LSB +: dmab_pkg::WID_W]);
      // Feedback modes always see the output register, never a loop
      fb = (md == dmab_pkg::DMAB_ACC) || cf[dmab_pkg::CFG_LOOP];
      for (int k = 0; k < NM; k++) begin
        m[k] = mul(36'(state_ff.a[h][k]), 36'(state_ff.b[h][k]), OPW, OPW,
                   state_ff.sa[h], state_ff.sb[h]);
      end
      p0 = cf[dmab_pkg::CFG_SUB] ? 37'(m[0] - m[1]) : 37'(m[0] + m[1]);
      p1 = cf[dmab_pkg::CFG_SUB] ? 37'(m[2] - m[3]) : 37'(m[2] + m[3]);
      s1 = '0;
      case (md)
        dmab_pkg::DMAB_IND: begin
          case (wd)
            dmab_pkg::DMAB_W9: begin
              for (int k = 0; k < NM; k++) begin
                t0 = 45'(mul(36'(state_ff.a[h][k][dmab_pkg::W9-1:0]),
                             36'(state_ff.b[h][k][dmab_pkg::W9-1:0]), dmab_pkg::W9,
                             dmab_pkg::W9, state_ff.sa[h], state_ff.sb[h]));
                s1[k*2*dmab_pkg::W9 +: 2*dmab_pkg::W9] = t0[2*dmab_pkg::W9-1:0];
              end
            end
            dmab_pkg::DMAB_W12: begin
              for (int k = 0; k < NM - 1; k++) begin
                t0 = 45'(mul(36'(state_ff.a[h][k][dmab_pkg::W12-1:0]),
                             36'(state_ff.b[h][k][dmab_pkg::W12-1:0]), dmab_pkg::W12,
                             dmab_pkg::W12, state_ff.sa[h], state_ff.sb[h]));
                s1[k*2*dmab_pkg::W12 +: 2*dmab_pkg::W12] = t0[2*dmab_pkg::W12-1:0];
              end
            end
            dmab_pkg::DMAB_W18: s1 = {44'(m[1]), 44'(m[0])};
            default: s1 = 88'(mul({state_ff.a[h][1], state_ff.a[h][0]},
                                  {state_ff.b[h][1], state_ff.b[h][0]}, dmab_pkg::WIDEW,
                                  dmab_pkg::WIDEW, state_ff.sa[h], state_ff.sb[h]));
          endcase
        end
        dmab_pkg::DMAB_TWO, dmab_pkg::DMAB_FOUR, dmab_pkg::DMAB_ACC:
          s1 = {44'($signed(p1)), 44'($signed(p0))};
        dmab_pkg::DMAB_SHIFT:
          s1 = 88'(shf({state_ff.a[h][1][dmab_pkg::SHH-1:0],
                        state_ff.a[h][0][dmab_pkg::SHH-1:0]},
                       state_ff.b[h][0][4:0], state_ff.sop[h]));
        dmab_pkg::DMAB_HP: begin
          hp0 = mul(36'(state_ff.a[h][0]), {state_ff.b[h][1], state_ff.b[h][0]}, OPW,
                    dmab_pkg::WIDEW, state_ff.sa[h], state_ff.sb[h]);
          hp1 = mul(36'(state_ff.a[h][2]), {state_ff.b[h][3], state_ff.b[h][2]}, OPW,
                    dmab_pkg::WIDEW, state_ff.sa[h], state_ff.sb[h]);
          s1  = 88'(hp0 + hp1);
        end
        default: s1 = '0;
      endcase
      if (ena) begin
        nxt_state.pipe[h] = s1;
      end
      stg = cf[dmab_pkg::CFG_PIPE] ? state_ff.pipe[h] : s1;
      s2  = stg;
      fa  = 1'b0;
      fs  = 1'b0;
      fc  = 1'b0;
      // Second-stage 44-bit adder
      z   = stg[AW-1:0] + stg[2*AW-1:AW];
      z_dbg[h] = z;
      case (md)
        dmab_pkg::DMAB_TWO, dmab_pkg::DMAB_IND: begin
          if (md == dmab_pkg::DMAB_TWO || wd == dmab_pkg::DMAB_W18) begin
            t0 = sat(rnd(stg[AW-1:0], cf[dmab_pkg::CFG_RND]), cf[dmab_pkg::CFG_SAT]);
            t1 = sat(rnd(stg[2*AW-1:AW], cf[dmab_pkg::CFG_RND]), cf[dmab_pkg::CFG_SAT]);
            s2 = {t1[AW-1:0], t0[AW-1:0]};
            fs = t0[AW] | t1[AW];
          end
        end
        dmab_pkg::DMAB_FOUR: begin
          t0 = sat(rnd(z, cf[dmab_pkg::CFG_RND]), cf[dmab_pkg::CFG_SAT]);
          fs = t0[AW];
          s2 = 88'(t0[AW-1:0]);
          if (cf[dmab_pkg::CFG_CHAIN]) begin
            // Top half takes the neighbour block, bottom half takes the top half
            cin = (h == 0) ? chain_in : res[0][AW-1:0];
            c   = {cin[AW-1], cin} + {t0[AW-1], t0[AW-1:0]};
            s2  = 88'(c[AW-1:0]);
            if (c[AW] != c[AW-1] && cf[dmab_pkg::CFG_SAT]) begin
              fc = 1'b1;
              s2 = 88'(c[AW] ? ~WRAP_MAX : WRAP_MAX);
            end
          end
        end
        dmab_pkg::DMAB_ACC: begin
          c  = state_ff.asub[h]
             ? {state_ff.outr[h][AW-1], state_ff.outr[h][AW-1:0]} - {z[AW-1], z}
             : {state_ff.outr[h][AW-1], state_ff.outr[h][AW-1:0]} + {z[AW-1], z};
          fa = c[AW] ^ c[AW-1];
          t0 = sat(rnd(c[AW-1:0], cf[dmab_pkg::CFG_RND]), cf[dmab_pkg::CFG_SAT]);
          fs = t0[AW];
          s2 = 88'(t0[AW-1:0]);
        end
        default: ;
      endcase
      if (ena) begin
        nxt_state.outr[h]  = s2;
        nxt_state.aovf[h]  = fa;
        nxt_state.sovf[h]  = fs;
        nxt_state.csovf[h] = fc;
      end
      res[h] = (cf[dmab_pkg::CFG_OUT] || fb) ? state_ff.outr[h] : s2;
      if (ena) begin
        nxt_state.sa[h]   = sign_a[h];
        nxt_state.sb[h]   = sign_b[h];
        nxt_state.asub[h] = acc_sub[h];
        nxt_state.sop[h]  = shift_op[h];
        for (int k = 0; k < NM; k++) begin
          nxt_state.a[h][k] = op_a[h][k];
          nxt_state.b[h][k] = op_b[h][k];
          if (cf[dmab_pkg::CFG_TAP]) begin
            if (k != 0) begin
              nxt_state.a[h][k] = state_ff.a[h][k-1];
            end else begin
              nxt_state.a[h][k] = (h == 0) ? scan_in : state_ff.a[0][NM-1];
            end
          end
        end
        if (cf[dmab_pkg::CFG_LOOP]) begin
          nxt_state.b[h][0] = state_ff.outr[h][dmab_pkg::LOOP_LSB +: OPW];
        end
      end
    end
    // APB: writes take effect in the access cycle, reads sampled at setup
    hit = (paddr == dmab_pkg::ADDR_CFG0) || (paddr == dmab_pkg::ADDR_CFG1)
       || (paddr == dmab_pkg::ADDR_STAT);
    if (psel && penable && pwrite) begin
      if (paddr == dmab_pkg::ADDR_CFG0) begin
        nxt_state.cfg[0] = pwdata[dmab_pkg::CFG_W-1:0];
      end
      if (paddr == dmab_pkg::ADDR_CFG1) begin
        nxt_state.cfg[1] = pwdata[dmab_pkg::CFG_W-1:0];
      end
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        dmab_pkg::ADDR_CFG0: nxt_state.rdata = 32'(state_ff.cfg[0]);
        dmab_pkg::ADDR_CFG1: nxt_state.rdata = 32'(state_ff.cfg[1]);
        dmab_pkg::ADDR_STAT: begin
          nxt_state.rdata = 32'h0000_0000;
          nxt_state.rdata[dmab_pkg::STAT_AOVF +: NH]  = state_ff.aovf;
          nxt_state.rdata[dmab_pkg::STAT_SOVF +: NH]  = state_ff.sovf;
          nxt_state.rdata[dmab_pkg::STAT_CSOVF +: NH] = state_ff.csovf;
        end
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end
    pslverr = psel && penable && (!hit || (pwrite && paddr == dmab_pkg::ADDR_STAT));
    result  = res;
  end

  // Clear is asynchronous; everything powers up at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pready        = 1'b1;
  assign prdata        = state_ff.rdata;
  assign scan_out      = state_ff.a[NH-1][NM-1];
  assign chain_out     = state_ff.outr[NH-1][AW-1:0];
  assign acc_ovf       = state_ff.aovf;
  assign sat_ovf       = state_ff.sovf;
  assign chain_sat_ovf = state_ff.csovf;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg0_write;
    psel && !penable && pwrite && paddr == dmab_pkg::ADDR_CFG0 ##1 psel && penable;
  endsequence

  chk_cfg_half_indep: assert property (
    s_cfg0_write |=> state_ff.cfg[0] == $past(pwdata[15:0]) && $stable(state_ff.cfg[1]))
    else $error("half configuration write wrong");

  chk_enable_hold: assert property (
    !ena [*2] |-> $stable(state_ff.outr) && $stable(state_ff.a) && $stable(acc_ovf))
    else $error("registers moved with enable low");

  chk_two_mult_sum: assert property (
    ena && state_ff.cfg[0][2:0] == dmab_pkg::DMAB_TWO && state_ff.cfg[0][12:6] == 7'h02
    |=> result[0][43:0] == 44'($past(state_ff.cfg[0][5]
          ? mul(36'(state_ff.a[0][0]), 36'(state_ff.b[0][0]), OPW, OPW, state_ff.sa[0],
                state_ff.sb[0]) - mul(36'(state_ff.a[0][1]), 36'(state_ff.b[0][1]), OPW, OPW,
                state_ff.sa[0], state_ff.sb[0])
          : mul(36'(state_ff.a[0][0]), 36'(state_ff.b[0][0]), OPW, OPW, state_ff.sa[0],
                state_ff.sb[0]) + mul(36'(state_ff.a[0][1]), 36'(state_ff.b[0][1]), OPW, OPW,
                state_ff.sa[0], state_ff.sb[0]))))
    else $error("two-multiplier sum wrong");

  chk_acc_feedback: assert property (
    ena && state_ff.cfg[1][2:0] == dmab_pkg::DMAB_ACC && state_ff.cfg[1][10:9] == 2'h0
      && !state_ff.cfg[1][6]
    |=> result[1][43:0] == $past(state_ff.asub[1] ? state_ff.outr[1][43:0] - z_dbg[1]
                                                  : state_ff.outr[1][43:0] + z_dbg[1]))
    else $error("accumulator update wrong");

  chk_acc_registered: assert property (
    state_ff.cfg[1][2:0] == dmab_pkg::DMAB_ACC |-> result[1] == state_ff.outr[1])
    else $error("accumulate output not registered");

  chk_chain_link: assert property (
    ena && state_ff.cfg[1][2:0] == dmab_pkg::DMAB_FOUR && state_ff.cfg[1][10:6] == 5'h06
    |=> result[1][43:0] == $past(z_dbg[1] + result[0][43:0]))
    else $error("chain sum wrong");

  chk_shift_rot: assert property (
    ena && state_ff.cfg[0][2:0] == dmab_pkg::DMAB_SHIFT && !state_ff.cfg[0][6]
      && state_ff.sop[0] == dmab_pkg::DMAB_SH_ROT && state_ff.cfg[0][7]
    |=> result[0][31:0] == $past({state_ff.a[0][1][15:0], state_ff.a[0][0][15:0]}
          << state_ff.b[0][0][4:0] | {state_ff.a[0][1][15:0], state_ff.a[0][0][15:0]}
          >> (6'd32 - 6'(state_ff.b[0][0][4:0]))))
    else $error("rotation wrong");

  chk_sat_clamp: assert property (
    sat_ovf[0] && state_ff.cfg[0][8:7] == 2'h1
      && (state_ff.cfg[0][2:0] == dmab_pkg::DMAB_FOUR
          || state_ff.cfg[0][2:0] == dmab_pkg::DMAB_TWO)
    |-> result[0][43:0] == SAT_MAX || result[0][43:0] == SAT_MIN
      || result[0][87:44] == SAT_MAX || result[0][87:44] == SAT_MIN)
    else $error("saturation not clamped");

  chk_loop_feed: assert property (
    ena && state_ff.cfg[0][12] |=> state_ff.b[0][0] == $past(state_ff.outr[0][43:26])
      && state_ff.b[0][1] == $past(op_b[0][1]))
    else $error("loopback operand wrong");

  chk_tap_shift: assert property (
    ena && state_ff.cfg[0][11] |=> state_ff.a[0][1] == $past(state_ff.a[0][0])
      && state_ff.a[0][0] == $past(scan_in))
    else $error("tap delay line wrong");

endmodule // dmab_core

/* File: test/dmab_nbr_model.sv */
`timescale 1ns/1ps
module dmab_nbr_model (
  // Clock and clear
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Value the preceding block registers next
  input  wire logic [43:0] nxt_chain,
  // Dedicated links into the block
  output logic      [43:0] chain_ff,
  output logic      [17:0] scan_ff
);
  // Driven only from this neighbour's own output register, never from loose logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_ff <= '0;
      scan_ff  <= '0;
    end else begin
      chain_ff <= nxt_chain;
      scan_ff  <= nxt_chain[17:0];
    end
  end
endmodule // dmab_nbr_model

/* File: test/tb_dsp_multiply_add_block.sv */
`timescale 1ns/1ps
module tb_dsp_multiply_add_block;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, ena, err;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [1:0][3:0][17:0] op_a, op_b;
  logic [1:0]            sign_a, sign_b, acc_sub, acc_ovf, sat_ovf, chain_sat_ovf;
  logic [1:0][2:0]       shift_op;
  logic [17:0]           scan_in, scan_out;
  logic [43:0]           chain_in, chain_out, nxt_chain;
  logic [1:0][87:0]      result;
  logic [31:0]           sh_exp [5];
  int                    n_mismatch, n_compared;

  dmab_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ena, .op_a, .op_b, .sign_a, .sign_b, .acc_sub, .shift_op, .scan_in, .scan_out,
    .chain_in, .chain_out, .result, .acc_ovf, .sat_ovf, .chain_sat_ovf);
  dmab_nbr_model nbr (.pclk, .presetn, .nxt_chain, .chain_ff(chain_in), .scan_ff(scan_in));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task check(input logic [87:0] got, input logic [87:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Starts on a fresh edge so a release and the next setup never share a time step
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    ena     <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, ena, paddr, pwdata} = '0;
    {op_a, op_b, sign_a, sign_b, acc_sub, shift_op, nxt_chain} = '0;
    n_mismatch = 0;
    n_compared = 0;
    sh_exp = '{32'h0000_0810, 32'h0F00_0008, 32'h0000_0810, 32'hFF00_0008, 32'h0000_081F};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(dmab_pkg::ADDR_CFG0, 1'b0, 32'h0000_0000);
    check(rd, 88'h0);
    apb(8'h0C, 1'b0, 32'h0000_0000);
    check({err, rd}, 88'h1_0000_0000);
    apb(dmab_pkg::ADDR_STAT, 1'b1, 32'h0000_00FF);
    check(err, 88'h1);
    check(result[0] | result[1], 88'h0);
    $display("test reset done");
    // Subtracting pairs in one half while the other sums four signed products
    apb(dmab_pkg::ADDR_CFG0, 1'b1, 32'h0000_00B1);
    apb(dmab_pkg::ADDR_CFG1, 1'b1, 32'h0000_0092);
    apb(dmab_pkg::ADDR_CFG1, 1'b0, 32'h0000_0000);
    check(rd, 88'h92);
    @(posedge pclk);
    op_a[0] <= {18'd1, 18'd4, 18'd7, 18'd3};
    op_b    <= {2{18'd9, 18'd6, 18'd2, 18'd5}};
    op_a[1] <= {18'd1, 18'd4, 18'd7, 18'h3_FFE2};
    sign_a  <= 2'b10;
    ena     <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check(result[0], {44'd15, 44'd1});
    check(result[1], {44'd0, 44'hFFF_FFFF_FF99});
    check(chain_out, 88'hFFF_FFFF_FF99);
    $display("test sum modes done");
    // Accumulate, hold while disabled, then subtract
    rst();
    apb(dmab_pkg::ADDR_CFG1, 1'b1, 32'h0000_0093);
    op_a[1] <= {18'd1, 18'd4, 18'd7, 18'd3};
    sign_a  <= 2'b00;
    ena     <= 1'b1;
    repeat (3) @(posedge pclk);
    ena     <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    check(result[1], 88'd124);
    @(posedge pclk);
    acc_sub <= 2'b10;
    ena     <= 1'b1;
    repeat (3) @(posedge pclk);
    ena     <= 1'b0;
    @(posedge pclk);
    #1;
    check(result[1], 88'd62);
    $display("test accumulate done");
    // Largest negative squared twice overflows the 36-bit signed range
    rst();
    apb(dmab_pkg::ADDR_CFG0, 1'b1, 32'h0000_0491);
    op_a[0] <= {36'd0, 18'h2_0000, 18'h2_0000};
    op_b[0] <= {36'd0, 18'h2_0000, 18'h2_0000};
    sign_a  <= 2'b01;
    sign_b  <= 2'b01;
    acc_sub <= 2'b00;
    ena     <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check(result[0], {44'd0, 44'h7_FFFF_FFFF});
    check(sat_ovf, 88'h1);
    apb(dmab_pkg::ADDR_STAT, 1'b0, 32'h0000_0000);
    check(rd, 88'h4);
    $display("test saturation done");
    // Shift kind changes on every cycle, results follow two edges later
    apb(dmab_pkg::ADDR_CFG0, 1'b1, 32'h0000_009C);
    op_a[0] <= {36'd0, 18'h0_F000, 18'h0_0081};
    op_b[0] <= {54'd0, 18'd4};
    sign_a  <= 2'b00;
    sign_b  <= 2'b00;
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      if (i < 5)
        shift_op[0] <= 3'(i);
      #1;
      if (i >= 2)
        check(result[0][31:0], sh_exp[i-2]);
    end
    $display("test shift done");
    // Tap line fills half0 A from the neighbour; loopback zeroes B of mult0
    apb(dmab_pkg::ADDR_CFG0, 1'b1, 32'h0000_1890);
    op_b[0]   <= {36'd0, 18'd5, 18'd5};
    nxt_chain <= 44'd3;
    repeat (6) @(posedge pclk);
    #1;
    check(result[0], {44'hF, 44'h0});
    $display("test tap loopback done");
    print_verdict();
  end
endmodule // tb_dsp_multiply_add_block
